// ---- src/sdli_defines.svh ----
// Purpose: constants of the serial load interface
// Assumes: one system clock, serial pins sampled as synchronous inputs
// Notes: frame is a 4-bit control field followed by 12 data bits
`ifndef SDLI_DEFINES_SVH
`define SDLI_DEFINES_SVH

`define SDLI_FRAME_BITS 16
`define SDLI_DATA_BITS 12
`define SDLI_CTRL_MSB 15
`define SDLI_CTRL_LSB 12
`define SDLI_DATA_MSB 11
`define SDLI_DATA_LSB 0
`define SDLI_CNT_LAST 5'h10
`define SDLI_CNT_FINAL 5'h0F
`define SDLI_SHIFT_RST 16'h0000
`define SDLI_CODE_RST 12'h000

`endif

// ---- src/sdli_pkg.sv ----
// Purpose: types of the serial load interface
// Assumes: sdli_defines.svh holds the numeric constants
// Notes: control codes of the leading frame field
package sdli_pkg;
	typedef enum logic [3:0] {
		SDLI_CMD_NOP = 4'h0,
		SDLI_CMD_LOAD = 4'h1,
		SDLI_CMD_READBACK = 4'h2,
		SDLI_CMD_DAISY = 4'h9,
		SDLI_CMD_EDGE_RISE = 4'hB,
		SDLI_CMD_EDGE_FALL = 4'hC
	} sdli_cmd_t;
endpackage

// ---- src/sdli_edge_detect.sv ----
// Purpose: edge strobes of the serial clock pin
// Assumes: serial clock is sampled as a synchronous input
// Notes: select chooses which edge is the sampling edge
`timescale 1ns/1ps
`default_nettype none
module sdli_edge_detect (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic sclk_i,
	input wire logic rise_sel_i,
	output logic sample_o,
	output logic launch_o
);
	logic prev_q;
	logic rise;
	logic fall;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			// take the pin level so neither idle level looks like an edge
			prev_q <= sclk_i;
		end else begin
			prev_q <= sclk_i;
		end
	end

	assign rise = sclk_i & ~prev_q;
	assign fall = ~sclk_i & prev_q;
	// launch is always the edge opposite the sampling edge
	assign sample_o = rise_sel_i ? rise : fall;
	assign launch_o = rise_sel_i ? fall : rise;
endmodule
`default_nettype wire

// ---- src/sdli_core.sv ----
// Purpose: three-wire serial load interface of a 12-bit converter
// Assumes: frame select, serial clock and data sampled on clk_i
// Notes: brownout detect is an input and clears like reset
//
// Function
// - default sampling on falling serial clock edge
// - control word selects rising sampling edge
// - sixteen-bit shift register fed on active edge
// - frame select low enables shifting logic
// - sixteenth active edge latches the frame
// - output changes on edge opposite sampling
// - shift register streams out for chaining
// - readback word presents converter register
// - shift register separate from converter register
// - converter register holds twelve-bit code
// - power-up clears all registers to zero except the serial clock history, which takes the pin level
// - brownout applies the same clearing
`timescale 1ns/1ps
`default_nettype none
`include "sdli_defines.svh"
module sdli_core #(
	parameter int FRAME_BITS = `SDLI_FRAME_BITS,
	parameter int DATA_BITS = `SDLI_DATA_BITS
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic brownout_i,
	input wire logic frame_sel_b_i,
	input wire logic sclk_i,
	input wire logic serial_data_in_i,
	output logic serial_data_out_o,
	output logic [DATA_BITS-1:0] dac_code_o,
	output logic rise_edge_o
);
	import sdli_pkg::*;

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	// slices and counts below are fixed to one frame layout
	if (FRAME_BITS != 16 || DATA_BITS != 12) begin : g_bad_size
		$error("sdli_core supports a 16-bit frame with 12 data bits");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic clr;
	logic sample;
	logic launch;
	logic active;
	logic [15:0] shift_q;
	logic [4:0] cnt_q;
	logic [11:0] code_q;
	logic rise_q;
	logic daisy_q;
	logic rdbk_q;
	logic [11:0] rdbk_sh_q;
	logic sdo_q;
	logic [15:0] frame;
	sdli_cmd_t cmd;

	assign clr = !rst_b_i || brownout_i;
	assign active = !frame_sel_b_i;
	// completed frame including the bit taken on this edge
	assign frame = {shift_q[14:0], serial_data_in_i};
	assign cmd = sdli_cmd_t'(frame[`SDLI_CTRL_MSB:`SDLI_CTRL_LSB]);

	// edge history is one clk deep: each sclk level needs one clk cycle
	sdli_edge_detect u_edge (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.sclk_i(sclk_i),
		.rise_sel_i(rise_q),
		.sample_o(sample),
		.launch_o(launch)
	);

	// ----------------------------------------------------------------
	// shift register and edge counter
	// ----------------------------------------------------------------
	// count saturates so extra edges can never reach a second latch
	always_ff @(posedge clk_i) begin
		if (clr) begin
			shift_q <= `SDLI_SHIFT_RST;
			cnt_q <= 5'h00;
		end else if (!active) begin
			cnt_q <= 5'h00;
		end else if (sample) begin
			shift_q <= frame;
			if (cnt_q != `SDLI_CNT_LAST) begin
				cnt_q <= cnt_q + 5'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// frame latch and control decode
	// ----------------------------------------------------------------
	logic last_edge;
	assign last_edge = active && sample
		&& cnt_q == `SDLI_CNT_FINAL;
	// readback mode lasts only until the next completed frame

	always_ff @(posedge clk_i) begin
		if (clr) begin
			code_q <= `SDLI_CODE_RST;
			rise_q <= 1'b0;
			daisy_q <= 1'b0;
			rdbk_q <= 1'b0;
		end else if (last_edge) begin
			rdbk_q <= 1'b0;
			unique case (cmd)
				SDLI_CMD_LOAD: code_q <= frame[`SDLI_DATA_MSB:`SDLI_DATA_LSB];
				SDLI_CMD_READBACK: rdbk_q <= 1'b1;
				SDLI_CMD_DAISY: daisy_q <= 1'b1;
				SDLI_CMD_EDGE_RISE: rise_q <= 1'b1;
				SDLI_CMD_EDGE_FALL: rise_q <= 1'b0;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// serial data out
	// ----------------------------------------------------------------
	// readback copy is taken when the readback word latches so the
	// next frame streams the converter code while new data shifts in
	always_ff @(posedge clk_i) begin
		if (clr) begin
			rdbk_sh_q <= 12'h000;
			sdo_q <= 1'b0;
		end else if (last_edge && cmd == SDLI_CMD_READBACK) begin
			rdbk_sh_q <= code_q;
		end else if (active && launch) begin
			if (rdbk_q) begin
				sdo_q <= rdbk_sh_q[11];
				rdbk_sh_q <= {rdbk_sh_q[10:0], 1'b0};
			end else begin
				sdo_q <= shift_q[15];
			end
		end
	end

	assign serial_data_out_o = sdo_q;
	assign dac_code_o = code_q;
	assign rise_edge_o = rise_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_idle_hold: assert property (@(posedge clk_i) disable iff (clr)
		frame_sel_b_i |=> $stable(shift_q) && $stable(code_q))
		else $error("registers changed while frame select high");
	chk_clear_zero: assert property (@(posedge clk_i)
		!rst_b_i |=> code_q == 12'h000 && shift_q == 16'h0000)
		else $error("reset did not clear registers");
	chk_brown_zero: assert property (@(posedge clk_i)
		brownout_i |=> code_q == 12'h000 && !rise_q)
		else $error("brownout did not clear registers");
	chk_load_code: assert property (@(posedge clk_i) disable iff (clr)
		last_edge && cmd == SDLI_CMD_LOAD |=> code_q == $past(frame[11:0]))
		else $error("load frame did not set converter code");
	chk_code_stable: assert property (@(posedge clk_i) disable iff (clr)
		!last_edge |=> $stable(code_q))
		else $error("converter code changed mid frame");
	chk_shift_in: assert property (@(posedge clk_i) disable iff (clr)
		active && sample |=> shift_q[0] == $past(serial_data_in_i))
		else $error("data bit not shifted in");
	chk_edge_rise: assert property (@(posedge clk_i) disable iff (clr)
		last_edge && cmd == SDLI_CMD_EDGE_RISE |=> rise_q)
		else $error("rising edge select not taken");
	chk_sdo_launch: assert property (@(posedge clk_i) disable iff (clr)
		!(active && launch) && !last_edge |=> $stable(sdo_q))
		else $error("serial out changed off launch edge");
	chk_chain_out: assert property (@(posedge clk_i) disable iff (clr)
		active && launch && !rdbk_q && !last_edge
		|=> sdo_q == $past(shift_q[15]))
		else $error("chain output wrong");
	chk_count_frame: assert property (@(posedge clk_i) disable iff (clr)
		frame_sel_b_i |=> cnt_q == 5'h00)
		else $error("edge count not reset between frames");

	// ----------------------------------------------------------------
	// checks of modes, sampling edges and serial out
	// ----------------------------------------------------------------
	// sclk history in these checks matches the edge detector's one deep
	chk_edge_fall: assert property (@(posedge clk_i) disable iff (clr)
		last_edge && cmd == SDLI_CMD_EDGE_FALL |=> !rise_q)
		else $error("falling edge select not taken");
	chk_rdbk_copy: assert property (@(posedge clk_i) disable iff (clr)
		last_edge && cmd == SDLI_CMD_READBACK
		|=> rdbk_q && rdbk_sh_q == $past(code_q))
		else $error("readback copy not taken");
	chk_rdbk_out: assert property (@(posedge clk_i) disable iff (clr)
		active && launch && rdbk_q && !last_edge
		|=> sdo_q == $past(rdbk_sh_q[11]))
		else $error("readback bit not presented");
	chk_daisy_flag: assert property (@(posedge clk_i) disable iff (clr)
		last_edge && cmd == SDLI_CMD_DAISY |=> daisy_q)
		else $error("daisy chain mode not recorded");
	chk_fall_shift: assert property (@(posedge clk_i) disable iff (clr)
		active && !rise_q && $fell(sclk_i)
		|=> shift_q == {$past(shift_q[14:0]), $past(serial_data_in_i)})
		else $error("falling edge did not shift data");
	chk_rise_shift: assert property (@(posedge clk_i) disable iff (clr)
		active && rise_q && $rose(sclk_i)
		|=> shift_q == {$past(shift_q[14:0]), $past(serial_data_in_i)})
		else $error("rising edge did not shift data");
	chk_rise_launch: assert property (@(posedge clk_i) disable iff (clr)
		active && !rise_q && $rose(sclk_i) && !rdbk_q
		|=> sdo_q == $past(shift_q[15]))
		else $error("serial out not launched on rising edge");
	chk_fall_launch: assert property (@(posedge clk_i) disable iff (clr)
		active && rise_q && $fell(sclk_i) && !rdbk_q
		|=> sdo_q == $past(shift_q[15]))
		else $error("serial out not launched on falling edge");
	chk_frame_hold: assert property (@(posedge clk_i) disable iff (clr)
		active && sample && !last_edge
		|=> $stable(rise_q) && $stable(rdbk_q) && $stable(daisy_q))
		else $error("mode changed before sixteenth edge");
	chk_nop_hold: assert property (@(posedge clk_i) disable iff (clr)
		last_edge && cmd != SDLI_CMD_LOAD |=> $stable(code_q))
		else $error("non-load frame changed converter code");
	chk_brown_pins: assert property (@(posedge clk_i)
		brownout_i |=> shift_q == 16'h0000 && cnt_q == 5'h00 && !sdo_q)
		else $error("brownout did not clear shift path");
	chk_reset_mode: assert property (@(posedge clk_i)
		!rst_b_i |=> !rise_q && !rdbk_q && !daisy_q && !sdo_q)
		else $error("reset did not clear modes");
endmodule
`default_nettype wire

// ---- bench/sdli_host_model.sv ----
// Purpose: host model driving frames into the load interface
// Assumes: each serial clock level held at least three system clocks
// Notes: serial clock idles low and stands still between frames
`timescale 1ns/1ps
`default_nettype none
module sdli_host_model (
	input wire logic clk_i,
	input wire logic data_back_i,
	output logic sel_b_o,
	output logic sclk_o,
	output logic data_o
);
	initial begin
		sel_b_o = 1'b1;
		sclk_o = 1'b0;
		data_o = 1'b0;
	end
	// n bits msb first; en low keeps select high so the pins are ignored
	task automatic frame(input logic [15:0] w, input int n, input logic en,
		output logic [15:0] rx);
		rx = 16'h0000;
		@(posedge clk_i);
		#2 sel_b_o = ~en;
		for (int i = 15; i > 15 - n; i--) begin
			data_o = w[i];
			repeat (3) @(posedge clk_i);
			#2 sclk_o = 1'b1;
			repeat (3) @(posedge clk_i);
			#2 rx[i] = data_back_i;
			sclk_o = 1'b0;
			repeat (3) @(posedge clk_i);
			#2;
		end
		sel_b_o = 1'b1;
		// released line must not keep showing the last bit
		data_o = ~data_o;
	endtask
endmodule
`default_nettype wire

// ---- bench/serial_dac_load_interface_test.sv ----
// Purpose: self-checking bench of the serial load interface
// Assumes: host model drives frames, lfsr gives data
// Notes: readback is judged on the first twelve bits out
`timescale 1ns/1ps
`default_nettype none
module serial_dac_load_interface_test;
	import sdli_pkg::*;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic brownout_i = 1'b0;
	logic sel_b, sclk, sdi, serial_data_out, rise;
	logic [11:0] code;
	logic [11:0] model_code = 12'h000;
	logic [15:0] rx, prev, word;
	logic [31:0] seed = 32'h0000_08DA;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	always #12.5 clk_i = ~clk_i;
	sdli_core DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .brownout_i(brownout_i),
		.frame_sel_b_i(sel_b), .sclk_i(sclk), .serial_data_in_i(sdi),
		.serial_data_out_o(serial_data_out), .dac_code_o(code), .rise_edge_o(rise));
	sdli_host_model host (.clk_i(clk_i), .data_back_i(serial_data_out), .sel_b_o(sel_b),
		.sclk_o(sclk), .data_o(sdi));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [11:0] exp_code(input logic [15:0] w,
		input logic [11:0] old);
		return (w[15:12] == SDLI_CMD_LOAD) ? w[11:0] : old;
	endfunction
	task automatic compare(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	// only a whole selected frame may move the code
	task automatic send(input logic [15:0] w, input int n, input logic en);
		host.frame(w, n, en, rx);
		if (n == 16 && en)
			model_code = exp_code(w, model_code);
		repeat (3) @(posedge clk_i);
		#2 compare("code", {4'h0, model_code}, {4'h0, code});
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		#2 rst_b_i = 1'b1;
		compare("code", 16'h0000, {4'h0, code});
		compare("rise", 16'h0000, {15'h0, rise});
		prev = 16'h0000;
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			word = (k == 0) ? 16'h1FFF : (k == 1) ? 16'h1000 : {4'h1, seed[11:0]};
			send(word, 16, 1'b1);
			compare("chain", prev, rx);
			prev = word;
		end
		$display("test loads done");
		send({4'h0, seed[11:0]}, 16, 1'b1);
		send(16'h1ABC, 8, 1'b1);
		send(16'h1ABC, 16, 1'b0);
		send(16'h2000, 16, 1'b1);
		send(16'h0000, 16, 1'b1);
		compare("readback", {model_code, 4'h0}, {rx[15:4], 4'h0});
		$display("test readback done");
		send(16'h9A5C, 16, 1'b1);
		send(16'hB000, 16, 1'b1);
		compare("chain", 16'h9A5C, rx);
		compare("rise", 16'h0001, {15'h0, rise});
		seed = lfsr(seed);
		send({4'h1, seed[11:0]}, 16, 1'b1);
		compare("chain", 16'h3000, {1'b0, rx[14:0]});
		send(16'hC000, 16, 1'b1);
		compare("rise", 16'h0000, {15'h0, rise});
		$display("test edge select done");
		send(16'hB000, 16, 1'b1);
		@(posedge clk_i);
		#2 brownout_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#2 brownout_i = 1'b0;
		model_code = 12'h000;
		compare("code", 16'h0000, {4'h0, code});
		compare("rise", 16'h0000, {15'h0, rise});
		$display("test brownout done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
